// file: shared/msb_regs.vh
// constants for the memory space decoder and external bus block
`ifndef MSB_REGS_VH
`define MSB_REGS_VH
`define MSB_SFR_STACK    8'h81
`define MSB_SFR_PAGE     8'h92
`define MSB_SFR_STATUS   8'hD0
`define MSB_STACK_RST    8'h07
`define MSB_PAGE_RST     8'h00
`define MSB_STATUS_RST   8'h00
`define MSB_BANK_HI      4
`define MSB_BANK_LO      3
`define MSB_BIT_BASE     8'h20
`define MSB_CFG_P0       1
`define MSB_CFG_P2       0
`define MSB_SRAM_TOP     16'h03FF
`define MSB_DFLASH_BASE  16'h0400
`define MSB_BOOT_BASE    16'hF800
`define MSB_RESET_PC     16'h0000
`define MSB_STRB_CYC     3'h4
`define MSB_IDLE_DATA    8'hFF
`define MSB_K_FETCH      2'h0
`define MSB_K_READ       2'h1
`define MSB_K_WRITE      2'h2
`define MSB_SP_SRAM      2'h0
`define MSB_SP_DFLASH    2'h1
`define MSB_SP_PROG      2'h2
`define MSB_SP_BOOT      2'h3
`define MSB_OP_DIR_RD    3'h0
`define MSB_OP_DIR_WR    3'h1
`define MSB_OP_IND_RD    3'h2
`define MSB_OP_IND_WR    3'h3
`define MSB_OP_BIT_RD    3'h4
`define MSB_OP_BIT_WR    3'h5
`define MSB_OP_PUSH      3'h6
`define MSB_OP_POP       3'h7
`endif

// file: rtl/msb_scratch.v
// 256-byte scratchpad ram held in flip-flops
`timescale 1ns/100ps
module msb_scratch (
    // clock
    input  wire       ref_clk,
    // access port
    input  wire [7:0] addr,
    input  wire       we,
    input  wire [7:0] wdata,
    output wire [7:0] rdata
);
    reg [7:0] mem [0:255];

    // storage has no reset; contents are undefined until written
    always @(posedge ref_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];
endmodule

// file: rtl/msb_bus.v
// memory space decoder, register space and multiplexed external bus
`timescale 1ns/100ps
`include "msb_regs.vh"
module msb_bus (
    // clock and reset
    input  wire        ref_clk,
    input  wire        arst_n,
    // configuration
    input  wire        external_fetch_select,
    input  wire [7:0]  hardware_config_byte_one,
    input  wire [1:0]  prog_size_sel,
    input  wire [2:0]  dflash_size_sel,
    input  wire        boot_rom_en,
    input  wire        memory_write_select,
    // code and data move requests
    input  wire        x_valid,
    input  wire [1:0]  x_kind,
    input  wire        x_short,
    input  wire [15:0] x_addr,
    input  wire [7:0]  x_wdata,
    output wire        x_ready,
    output reg         x_ack,
    output reg  [7:0]  x_rdata,
    output wire [15:0] fetch_addr,
    // on-chip memories
    output reg         im_en,
    output reg         im_we,
    output reg  [1:0]  im_space,
    output reg  [15:0] im_addr,
    output reg  [7:0]  im_wdata,
    input  wire [7:0]  im_rdata,
    // register space requests
    input  wire        ir_valid,
    input  wire [2:0]  ir_op,
    input  wire [7:0]  ir_addr,
    input  wire [7:0]  ir_wdata,
    output wire        ir_ready,
    output reg         ir_ack,
    output reg  [7:0]  ir_rdata,
    // other special function registers
    output wire        sfr_rd,
    output wire        sfr_we,
    output wire [7:0]  sfr_addr,
    output wire [7:0]  sfr_wdata,
    input  wire [7:0]  sfr_rdata,
    output wire [7:0]  stack_top_pointer,
    output wire [7:0]  processor_status_word,
    // gpio values
    input  wire [7:0]  p0_gpio_out,
    input  wire        p0_gpio_oe,
    input  wire [7:0]  p2_gpio_out,
    input  wire        p2_gpio_oe,
    input  wire        p36_gpio,
    input  wire        p37_gpio,
    // pins
    input  wire [7:0]  p0_in,
    output reg  [7:0]  p0_out,
    output reg         p0_oe,
    output reg  [7:0]  p2_out,
    output reg         p2_oe,
    output reg         ale,
    output reg         program_fetch_strobe_n,
    output reg         p36_out,
    output reg         p37_out,
    output reg         p3_strobe_oe
);
    localparam S_IDLE = 5'b00001;
    localparam S_ADDR = 5'b00010;
    localparam S_HOLD = 5'b00100;
    localparam S_DATA = 5'b01000;
    localparam S_STRB = 5'b10000;

    // ---- bit address to byte address
    function [7:0] bit_byte;
        input [7:0] b;
        begin
            if (b[7])
                bit_byte = {b[7:3], 3'b000};
            else
                bit_byte = `MSB_BIT_BASE + {4'h0, b[6:3]};
        end
    endfunction

    // ---- data flash size in bytes from partition select
    function [16:0] dflash_bytes;
        input [2:0] s;
        begin
            case (s)
                3'h1:    dflash_bytes = 17'h0_8000;
                3'h2:    dflash_bytes = 17'h0_4000;
                3'h3:    dflash_bytes = 17'h0_2000;
                3'h4:    dflash_bytes = 17'h0_1000;
                3'h5:    dflash_bytes = 17'h0_0800;
                3'h6:    dflash_bytes = 17'h0_0400;
                default: dflash_bytes = 17'h0_0000;
            endcase
        end
    endfunction

    // ---- pin synchronisers
    reg        ea_s1_r;
    reg        ea_s2_r;
    reg [7:0]  p0_s1_r;
    reg [7:0]  p0_s2_r;
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ea_s1_r <= 1'b0;
            ea_s2_r <= 1'b0;
            p0_s1_r <= 8'h00;
            p0_s2_r <= 8'h00;
        end else begin
            ea_s1_r <= external_fetch_select;
            ea_s2_r <= ea_s1_r;
            p0_s1_r <= p0_in;
            p0_s2_r <= p0_s1_r;
        end
    end

    // ---- configuration decode
    wire p0_ext  = ~hardware_config_byte_one[`MSB_CFG_P0];
    wire p2_ext  = ~hardware_config_byte_one[`MSB_CFG_P2];
    wire strb_md = p0_ext | p2_ext;
    wire ext_en  = p0_ext & p2_ext;

    // ---- register space
    reg  [7:0] sp_r;
    reg  [7:0] page_r;
    reg  [7:0] psw_r;
    reg        ir_ptr_r;
    reg  [2:0] ir_op_r;
    reg  [7:0] ir_wd_r;
    reg  [7:0] ir_bit_r;
    reg  [7:0] ra;
    reg        rwe;
    reg  [7:0] rwd;
    reg  [7:0] res;
    reg        dir_sfr;
    reg        sfr_w;
    reg        sfr_r;
    reg  [7:0] sfr_a;
    reg  [7:0] sfr_d;
    reg  [7:0] sp_nxt;
    reg  [7:0] cur;
    wire [7:0] ram_q;

    msb_scratch u_ram (
        .ref_clk (ref_clk),
        .addr    (ra),
        .we      (rwe),
        .wdata   (rwd),
        .rdata   (ram_q)
    );

    // working register address in the selected bank
    wire [7:0] wreg_a = {3'b000, psw_r[`MSB_BANK_HI:`MSB_BANK_LO],
                         ir_addr[2:0]};
    wire       ind_op = (ir_op == `MSB_OP_IND_RD) |
                        (ir_op == `MSB_OP_IND_WR);

    // value of a register-space byte for read-modify-write
    always @* begin
        ra      = 8'h00;
        rwe     = 1'b0;
        rwd     = 8'h00;
        res     = 8'h00;
        dir_sfr = 1'b0;
        sfr_w   = 1'b0;
        sfr_r   = 1'b0;
        sfr_a   = 8'h00;
        sfr_d   = 8'h00;
        sp_nxt  = sp_r;
        cur     = 8'h00;
        if (ir_ptr_r) begin
            // second step: working register value is the address
            ra  = ir_bit_r;
            rwe = (ir_op_r == `MSB_OP_IND_WR);
            rwd = ir_wd_r;
            res = ram_q;
        end else if (ir_valid && ind_op) begin
            ra  = wreg_a;
            res = ram_q;
        end else if (ir_valid) begin
            case (ir_op)
                `MSB_OP_PUSH: begin
                    sp_nxt = sp_r + 8'h01;
                    ra     = sp_nxt;
                    rwe    = 1'b1;
                    rwd    = ir_wdata;
                end
                `MSB_OP_POP: begin
                    ra     = sp_r;
                    res    = ram_q;
                    sp_nxt = sp_r - 8'h01;
                end
                default: begin
                    sfr_a = ir_addr;
                    if (ir_op[2])
                        sfr_a = bit_byte(ir_addr);
                    dir_sfr = sfr_a[7];
                    ra      = sfr_a;
                    case (sfr_a)
                        `MSB_SFR_STACK:  cur = sp_r;
                        `MSB_SFR_PAGE:   cur = page_r;
                        `MSB_SFR_STATUS: cur = psw_r;
                        default:         cur = dir_sfr ? sfr_rdata
                                                       : ram_q;
                    endcase
                    sfr_d = ir_wdata;
                    if (ir_op == `MSB_OP_BIT_WR) begin
                        sfr_d = cur;
                        sfr_d[ir_addr[2:0]] = ir_wdata[0];
                    end
                    res = cur;
                    if (ir_op == `MSB_OP_BIT_RD)
                        res = {7'h00, cur[ir_addr[2:0]]};
                    if (ir_op == `MSB_OP_DIR_WR ||
                        ir_op == `MSB_OP_BIT_WR) begin
                        rwe   = ~dir_sfr;
                        rwd   = sfr_d;
                        sfr_w = dir_sfr;
                        if (sfr_a == `MSB_SFR_STACK)
                            sp_nxt = sfr_d;
                    end else begin
                        sfr_r = dir_sfr;
                    end
                end
            endcase
        end
    end

    // outside registers are only touched when this block does not own them
    wire own = (sfr_a == `MSB_SFR_STACK) | (sfr_a == `MSB_SFR_PAGE) |
               (sfr_a == `MSB_SFR_STATUS);
    assign sfr_we    = sfr_w & ~own;
    assign sfr_rd    = sfr_r & ~own;
    assign sfr_addr  = sfr_a;
    assign sfr_wdata = sfr_d;
    assign ir_ready  = ~ir_ptr_r;
    assign stack_top_pointer     = sp_r;
    assign processor_status_word = psw_r;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sp_r     <= `MSB_STACK_RST;
            page_r   <= `MSB_PAGE_RST;
            psw_r    <= `MSB_STATUS_RST;
            ir_ptr_r <= 1'b0;
            ir_op_r  <= 3'h0;
            ir_wd_r  <= 8'h00;
            ir_bit_r <= 8'h00;
            ir_ack   <= 1'b0;
            ir_rdata <= 8'h00;
        end else begin
            sp_r     <= sp_nxt;
            if (sfr_w && sfr_a == `MSB_SFR_PAGE)
                page_r <= sfr_d;
            if (sfr_w && sfr_a == `MSB_SFR_STATUS)
                psw_r <= sfr_d;
            ir_ptr_r <= ir_valid & ind_op & ~ir_ptr_r;
            ir_bit_r <= ram_q;
            if (ir_valid && !ir_ptr_r) begin
                ir_op_r <= ir_op;
                ir_wd_r <= ir_wdata;
            end
            ir_ack   <= ir_ptr_r | (ir_valid & ~ind_op);
            if (ir_ptr_r || (ir_valid && !ind_op))
                ir_rdata <= res;
        end
    end

    // ---- code and data space decode
    wire [16:0] prog_lim = 17'h0_1000 << prog_size_sel;
    wire [16:0] dfl_lim  = {1'b0, `MSB_DFLASH_BASE} +
                           dflash_bytes(dflash_size_sel);
    reg         d_int;
    reg  [1:0]  d_space;
    reg         d_drop;
    always @* begin
        d_int   = 1'b0;
        d_space = `MSB_SP_SRAM;
        d_drop  = 1'b0;
        if (x_kind == `MSB_K_FETCH) begin
            if (boot_rom_en && x_addr >= `MSB_BOOT_BASE) begin
                d_int   = ea_s2_r;
                d_space = `MSB_SP_BOOT;
            end else begin
                // pin low sends every fetch outside
                d_int   = ea_s2_r &&
                          ({1'b0, x_addr} < prog_lim);
                d_space = `MSB_SP_PROG;
            end
        end else if (x_short) begin
            d_int = 1'b0;
        end else if (x_addr <= `MSB_SRAM_TOP) begin
            d_int = 1'b1;
        end else if ({1'b0, x_addr} < dfl_lim) begin
            d_int   = 1'b1;
            d_space = `MSB_SP_DFLASH;
            d_drop  = (x_kind == `MSB_K_WRITE) & ~memory_write_select;
        end
    end

    // ---- external bus sequencer
    reg  [4:0]  st_r;
    reg  [4:0]  st_nxt;
    reg  [2:0]  cnt_r;
    reg  [1:0]  kind_r;
    reg         int_r;
    reg         short_r;
    reg  [15:0] ab_r;
    reg  [7:0]  wd_r;
    reg  [15:0] pc_r;
    wire        take = x_valid && (st_r == S_IDLE);
    wire        last = (st_r == S_STRB) && (cnt_r == 3'h0);
    assign x_ready    = (st_r == S_IDLE);
    assign fetch_addr = pc_r;

    always @* begin
        st_nxt = st_r;
        case (st_r)
            S_IDLE: if (take && ext_en) st_nxt = S_ADDR;
            S_ADDR: st_nxt = S_HOLD;
            S_HOLD: st_nxt = S_DATA;
            S_DATA: st_nxt = S_STRB;
            S_STRB: if (cnt_r == 3'h0) st_nxt = S_IDLE;
            default: st_nxt = S_IDLE;
        endcase
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r     <= S_IDLE;
            cnt_r    <= 3'h0;
            kind_r   <= `MSB_K_FETCH;
            int_r    <= 1'b0;
            short_r  <= 1'b0;
            ab_r     <= 16'h0000;
            wd_r     <= 8'h00;
            pc_r     <= `MSB_RESET_PC;
            x_ack    <= 1'b0;
            x_rdata  <= 8'h00;
            im_en    <= 1'b0;
            im_we    <= 1'b0;
            im_space <= 2'h0;
            im_addr  <= 16'h0000;
            im_wdata <= 8'h00;
        end else begin
            st_r  <= st_nxt;
            x_ack <= 1'b0;
            im_en <= 1'b0;
            im_we <= 1'b0;
            cnt_r <= (st_r == S_DATA) ? `MSB_STRB_CYC - 3'h1 :
                     (cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0;
            if (take) begin
                kind_r  <= x_kind;
                int_r   <= d_int;
                short_r <= x_short;
                ab_r    <= x_addr;
                wd_r    <= x_wdata;
                if (x_kind == `MSB_K_FETCH)
                    pc_r <= x_addr;
                im_space <= d_space;
                im_addr  <= x_addr;
                im_wdata <= x_wdata;
                if (d_int) begin
                    // internal access runs now; bus only mirrors it
                    im_en <= 1'b1;
                    im_we <= (x_kind == `MSB_K_WRITE) & ~d_drop;
                end
                if (!ext_en) begin
                    // no bus: external accesses float high, pins untouched
                    x_ack   <= 1'b1;
                    x_rdata <= d_int ? im_rdata : `MSB_IDLE_DATA;
                end else if (d_int) begin
                    x_rdata <= im_rdata;
                end
            end
            if (last) begin
                x_ack <= 1'b1;
                if (!int_r && kind_r != `MSB_K_WRITE)
                    x_rdata <= p0_s2_r;
            end
        end
    end

    // ---- pin drivers, registered from next state
    wire        nb   = (st_nxt != S_IDLE);
    wire        n_ad = (st_nxt == S_ADDR) | (st_nxt == S_HOLD);
    wire        n_dt = (st_nxt == S_DATA) | (st_nxt == S_STRB);
    wire [1:0]  n_k  = take ? x_kind : kind_r;
    wire        n_i  = take ? d_int : int_r;
    wire        n_s  = take ? x_short : short_r;
    wire [15:0] n_a  = take ? x_addr : ab_r;
    wire [7:0]  n_w  = take ? x_wdata : wd_r;
    // strobe only during the last stretch, so data leads and trails it
    wire        n_st = (st_nxt == S_STRB) & ~n_i;
    wire        n_ws = n_st & (n_k == `MSB_K_WRITE);
    wire        n_rs = n_st & (n_k == `MSB_K_READ);
    wire        n_fs = n_st & (n_k == `MSB_K_FETCH);
    // write data outlasts the strobe by one cycle before the bus idles
    wire        trail = last & ~int_r & (kind_r == `MSB_K_WRITE);

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            p0_out  <= 8'h00;
            p0_oe   <= 1'b0;
            p2_out  <= 8'h00;
            p2_oe   <= 1'b0;
            ale     <= 1'b0;
            program_fetch_strobe_n <= 1'b1;
            p36_out <= 1'b1;
            p37_out <= 1'b1;
            p3_strobe_oe <= 1'b0;
        end else begin
            ale <= (st_nxt == S_ADDR);
            program_fetch_strobe_n <= ~n_fs;
            p3_strobe_oe <= strb_md;
            p36_out <= strb_md ? ~n_ws : p36_gpio;
            p37_out <= strb_md ? ~n_rs : p37_gpio;
            if (!ext_en || (!nb && !trail)) begin
                p0_out <= p0_ext ? 8'h00 : p0_gpio_out;
                p0_oe  <= p0_ext ? 1'b0 : p0_gpio_oe;
                p2_out <= p2_ext ? p2_gpio_out : p2_gpio_out;
                p2_oe  <= p2_ext ? 1'b1 : p2_gpio_oe;
            end else begin
                // port 2 driven for the whole cycle; port 0 floats in the data phase of external reads and fetches
                p2_oe <= 1'b1;
                p2_out <= n_s ? page_r : n_a[15:8];
                if (n_ad) begin
                    p0_out <= n_a[7:0];
                    p0_oe  <= 1'b1;
                end else if (n_dt && n_i) begin
                    p0_out <= 8'h00;
                    p0_oe  <= 1'b1;
                end else if (n_k == `MSB_K_WRITE) begin
                    p0_out <= n_w;
                    p0_oe  <= 1'b1;
                end else begin
                    p0_out <= 8'h00;
                    p0_oe  <= 1'b0;
                end
            end
        end
    end
endmodule

// file: tb/msb_bus_sva.sv
// assertions on the external bus pins and request handshakes
`timescale 1ns/100ps
module msb_chk (
    // clock and reset
    input logic        ref_clk,
    input logic        arst_n,
    // configuration and requests
    input logic [7:0]  hardware_config_byte_one,
    input logic        x_valid,
    input logic        x_ready,
    input logic        x_ack,
    input logic        ir_valid,
    input logic [2:0]  ir_op,
    input logic        ir_ready,
    input logic        ir_ack,
    input logic        im_en,
    // gpio and pins
    input logic [7:0]  p0_gpio_out,
    input logic        p0_gpio_oe,
    input logic [7:0]  p0_out,
    input logic        p0_oe,
    input logic [7:0]  p2_out,
    input logic        p2_oe,
    input logic        ale,
    input logic        program_fetch_strobe_n,
    input logic        p36_out,
    input logic        p37_out
);
    wire bus_on = hardware_config_byte_one[1:0] == 2'h0;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    latch_hold_a: assert property (
        ale |=> !ale && p0_oe && $stable(p0_out)) else $error("latch");
    write_data_a: assert property (
        !p36_out |-> p0_oe && $past(p0_oe) && $stable(p0_out))
        else $error("write data");
    write_width_a: assert property (
        $fell(p36_out) |-> !p36_out [*4] ##1 (p36_out && p0_oe))
        else $error("write strobe");
    read_float_a: assert property (
        !p37_out || !program_fetch_strobe_n |-> !p0_oe) else $error("rd");
    fetch_high_a: assert property (
        !program_fetch_strobe_n || !p37_out |-> p2_oe && $stable(p2_out)
        && (p37_out || program_fetch_strobe_n)) else $error("strobe");
    bus_off_a: assert property (
        !bus_on |-> !ale && program_fetch_strobe_n) else $error("bus off");
    gpio_keep_a: assert property (
        hardware_config_byte_one[1] |=> p0_out == $past(p0_gpio_out)
        && p0_oe == $past(p0_gpio_oe)) else $error("gpio");
    quick_ack_a: assert property (
        x_valid && x_ready && !bus_on |=> x_ack) else $error("ack");
    bus_ack_a: assert property (
        x_valid && x_ready && bus_on |=> !x_ack [*6] ##[1:2] x_ack)
        else $error("bus ack");
    hide_data_a: assert property (
        im_en && bus_on |-> ##2 (p0_oe && p0_out == 8'h00))
        else $error("hide");
    reg_ack_a: assert property (
        ir_valid && ir_ready && ir_op[2:1] != 2'h1 |=> ir_ack)
        else $error("reg ack");
    ind_ack_a: assert property (
        ir_valid && ir_ready && ir_op[2:1] == 2'h1 |=> !ir_ready ##1 ir_ack)
        else $error("ind ack");
endmodule
bind msb_bus msb_chk u_chk (.*);

// file: tb/msb_xmem.sv
// external memory with address latch on the multiplexed bus
`timescale 1ns/100ps
module msb_xmem (
    // clock
    input  logic        ref_clk,
    // bus pins
    input  logic        ale,
    input  logic        program_fetch_strobe_n,
    input  logic        p36_out,
    input  logic        p37_out,
    input  logic [7:0]  p0_out,
    input  logic [7:0]  p2_out,
    output logic [7:0]  p0_in,
    // observation
    output logic [15:0] xm_addr,
    output logic [7:0]  xm_cnt
);
    logic [7:0] mem [0:65535];
    logic [7:0] lat;
    logic [7:0] last = 8'h00;
    logic       armed = 1'h0;
    wire        rd_n = program_fetch_strobe_n & p37_out;
    initial begin
        xm_cnt = 8'h00;
        for (int i = 0; i < 65536; i++)
            mem[i] = i[7:0] ^ i[15:8];
    end
    always @(negedge ale)
        lat <= p0_out;
    always @(negedge rd_n or negedge p36_out) begin
        xm_addr <= {p2_out, lat};
        xm_cnt <= xm_cnt + 8'h01;
        armed <= !p36_out;
    end
    // write lands only at the end of a real strobe, not at power-up
    always @(posedge p36_out)
        if (armed)
            mem[{p2_out, lat}] <= p0_out;
    // undriven bus shows the inverse of the last byte, never a held value
    always @(posedge ref_clk)
        if (!rd_n)
            last <= p0_in;
    assign p0_in = rd_n ? ~last : mem[{p2_out, lat}];
endmodule

// file: tb/memory_space_and_external_bus_test.sv
// self-checking bench for the memory space decoder and external bus
`timescale 1ns/100ps
`include "msb_regs.vh"
module memory_space_and_external_bus_test;
    logic ref_clk = 1'h0, arst_n = 1'h0, external_fetch_select = 1'h1;
    logic boot_rom_en = 1'h1, memory_write_select = 1'h0, x_valid = 1'h0;
    logic x_short = 1'h0, ir_valid = 1'h0, p0_gpio_oe = 1'h1;
    logic p2_gpio_oe = 1'h1, p36_gpio = 1'h1, p37_gpio = 1'h1;
    logic x_ready, x_ack, im_en, im_we, ir_ready, ir_ack, sfr_rd, sfr_we;
    logic p0_oe, p2_oe, ale, program_fetch_strobe_n, p36_out, p37_out;
    logic p3_strobe_oe, we_seen = 1'h0;
    logic [1:0] prog_size_sel = 2'h0, x_kind = 2'h0, im_space, sp_seen;
    logic [2:0] dflash_size_sel = 3'h7, ir_op = 3'h0;
    logic [15:0] x_addr = 16'h0000, fetch_addr, im_addr, xm_addr;
    logic [7:0] hardware_config_byte_one = 8'hFF, x_wdata = 8'h00;
    logic [7:0] ir_addr = 8'h00, ir_wdata = 8'h00, ir_rdata, x_rdata;
    logic [7:0] sfr_rdata = 8'hC3, stack_top_pointer, processor_status_word;
    logic [7:0] p0_gpio_out = 8'h5A, p2_gpio_out = 8'h3C, p0_in, p0_out;
    logic [7:0] p2_out, im_wdata, im_rdata, sfr_addr, sfr_wdata, xm_cnt, c0;
    logic [15:0] ia [4] = '{16'h0FFF, 16'h03FF, 16'h0400, 16'hF800};
    logic [1:0] ik [4] = '{`MSB_K_FETCH, `MSB_K_READ, `MSB_K_READ,
                           `MSB_K_FETCH};
    logic [1:0] isp [4] = '{`MSB_SP_PROG, `MSB_SP_SRAM, `MSB_SP_DFLASH,
                            `MSB_SP_BOOT};
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    msb_bus dut (.*);
    msb_xmem xmem (.*);
    always #5 ref_clk = ~ref_clk;
    // on-chip memories answer with a byte derived from the address
    assign im_rdata = x_addr[7:0] ^ 8'hA5;
    always @(posedge ref_clk) begin
        cyc++;
        if (im_en === 1'h1)
            sp_seen = im_space;
        if (im_we === 1'h1)
            we_seen = 1'h1;
        if (cyc == 3000) begin
            fail_count++;
            wrap_up;
        end
    end
    task automatic chk(input string nm, input logic [23:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic bus(input logic [1:0] k, input logic s,
                       input logic [15:0] a, input logic [7:0] d);
        x_kind = k;
        x_short = s;
        x_addr = a;
        x_wdata = d;
        x_valid = 1'h1;
        @(posedge ref_clk);
        #1;
        x_valid = 1'h0;
        repeat (12) begin
            if (x_ack === 1'h1)
                break;
            @(posedge ref_clk);
            #1;
        end
        chk("x_ack", x_ack, 1'h1);
    endtask
    task automatic reg_op(input logic [2:0] op, input logic [7:0] a, d);
        ir_op = op;
        ir_addr = a;
        ir_wdata = d;
        ir_valid = 1'h1;
        @(posedge ref_clk);
        #1;
        ir_valid = 1'h0;
        repeat (3) begin
            if (ir_ack === 1'h1)
                break;
            @(posedge ref_clk);
            #1;
        end
        chk("ir_ack", ir_ack, 1'h1);
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        #1;
        arst_n = 1'h1;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("sp_rst", stack_top_pointer, 8'h07);
        chk("pc_rst", fetch_addr, 16'h0000);
        reg_op(`MSB_OP_DIR_WR, 8'hD0, 8'h18);
        reg_op(`MSB_OP_DIR_WR, 8'h18, 8'h90);
        reg_op(`MSB_OP_IND_WR, 8'h00, 8'h5A);
        reg_op(`MSB_OP_IND_RD, 8'h00, 8'h00);
        chk("ind_rd", ir_rdata, 8'h5A);
        reg_op(`MSB_OP_DIR_RD, 8'h90, 8'h00);
        chk("sfr_rd", ir_rdata, 8'hC3);
        reg_op(`MSB_OP_DIR_WR, 8'h20, 8'h00);
        reg_op(`MSB_OP_BIT_WR, 8'h07, 8'h01);
        reg_op(`MSB_OP_DIR_RD, 8'h20, 8'h00);
        chk("bit_ram", ir_rdata, 8'h80);
        reg_op(`MSB_OP_BIT_WR, 8'hD5, 8'h01);
        chk("bit_reg", processor_status_word, 8'h38);
        reg_op(`MSB_OP_PUSH, 8'h00, 8'h11);
        chk("sp_up", stack_top_pointer, 8'h08);
        reg_op(`MSB_OP_DIR_RD, 8'h08, 8'h00);
        chk("pushed", ir_rdata, 8'h11);
        reg_op(`MSB_OP_POP, 8'h00, 8'h00);
        chk("popped", ir_rdata, 8'h11);
        chk("sp_down", stack_top_pointer, 8'h07);
        reg_op(`MSB_OP_DIR_WR, 8'h92, 8'h7E);
        // bus disabled: access is answered but the pins stay gpio
        bus(`MSB_K_READ, 1'h0, 16'h8000, 8'h00);
        chk("off_data", x_rdata, 8'hFF);
        chk("off_pins", {xm_cnt, p0_out}, {8'h00, p0_gpio_out});
        hardware_config_byte_one = 8'hFC;
        bus(`MSB_K_FETCH, 1'h0, 16'h1234, 8'h00);
        chk("fetch_addr", xm_addr, 16'h1234);
        chk("fetch_data", x_rdata, 8'h26);
        bus(`MSB_K_WRITE, 1'h0, 16'h8000, 8'h99);
        bus(`MSB_K_READ, 1'h0, 16'h8000, 8'h00);
        chk("wr_back", {xm_addr, x_rdata}, 24'h8000_99);
        bus(`MSB_K_READ, 1'h1, 16'h0055, 8'h00);
        chk("page_rd", {xm_addr, x_rdata}, 24'h7E55_2B);
        dflash_size_sel = 3'h6;
        c0 = xm_cnt;
        for (int i = 0; i < 4; i++) begin
            bus(ik[i], 1'h0, ia[i], 8'h00);
            chk("space", sp_seen, isp[i]);
            chk("idata", x_rdata, ia[i][7:0] ^ 8'hA5);
        end
        bus(`MSB_K_WRITE, 1'h0, 16'h0400, 8'h11);
        chk("no_wr", we_seen, 1'h0);
        memory_write_select = 1'h1;
        bus(`MSB_K_WRITE, 1'h0, 16'h0400, 8'h11);
        chk("flash_wr", we_seen, 1'h1);
        chk("no_strobe", xm_cnt, c0);
        boot_rom_en = 1'h0;
        bus(`MSB_K_FETCH, 1'h0, 16'hF800, 8'h00);
        chk("boot_off", {xm_addr, x_rdata}, 24'hF800_F8);
        external_fetch_select = 1'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        bus(`MSB_K_FETCH, 1'h0, 16'h0100, 8'h00);
        chk("all_ext", {xm_addr, x_rdata}, 24'h0100_01);
        wrap_up;
    end
endmodule
